// >>> verilog/acc_pkg.sv
/*
 * Package for the comparator control block: register map, field layout and
 * control encodings.
 * Assumes a single 200 MHz core clock and a plain strobe register port.
 */
package acc_pkg;

    // Register indices; the port address i_addr equals the index.
    localparam logic [7:0] ACC_CTL1_IDX = 8'h00;
    localparam logic [7:0] ACC_CTL2_IDX = 8'h01;
    localparam logic [7:0] ACC_PD_IDX = 8'h02;
    localparam logic [7:0] ACC_IRQ_IDX = 8'h03;

    // Control 1 field positions.
    localparam int ACC_C1_EXCH = 7;
    localparam int ACC_C1_RSEL = 6;
    localparam int ACC_C1_REF_LO = 4;
    localparam int ACC_C1_ON = 3;
    localparam int ACC_C1_IES = 2;
    localparam int ACC_C1_IE = 1;
    localparam int ACC_C1_IFG = 0;

    // Control 2 field positions.
    localparam int ACC_C2_SHORT = 7;
    localparam int ACC_C2_SEL4 = 6;
    localparam int ACC_C2_SEL_MID = 3;
    localparam int ACC_C2_SEL0 = 2;
    localparam int ACC_C2_FILT = 1;
    localparam int ACC_C2_RES = 0;

    // Interrupt service register: bit 0 is the global enable.
    localparam int ACC_IRQ_GIE = 0;

    // Values after reset.
    localparam logic [7:0] ACC_CTL1_RST = 8'h00;
    localparam logic [7:0] ACC_CTL2_RST = 8'h00;
    localparam logic [7:0] ACC_PD_RST = 8'h00;

    // Filter length in cycles of the digital stand-in for the output filter.
    localparam int ACC_FILT_NS = 20;
    localparam int ACC_CLK_PERIOD_NS = 5;
    localparam int ACC_FILT_CYC = (ACC_FILT_NS + ACC_CLK_PERIOD_NS - 1) / ACC_CLK_PERIOD_NS;

    typedef enum logic [1:0] {
        ACC_REF_OFF,
        ACC_REF_QUARTER,
        ACC_REF_HALF,
        ACC_REF_DIODE
    } acc_ref_t;

    // Analog switch controls, grouped as they leave the block.
    typedef struct packed {
        logic [7:0] pin_to_pos;
        logic [7:0] pin_to_neg;
        logic short_en;
        logic cmp_on;
        acc_ref_t ref_level;
        logic ref_to_pos;
        logic ref_to_neg;
    } acc_analog_t;

endpackage

// >>> verilog/acc_ctrl.sv
/*
 * Digital control around an analog comparator: registers, input routing,
 * result conditioning, interrupt flag and timer capture output.
 * Assumes the raw comparator output arrives asynchronously on i_cmp_raw and
 * that the analog switches obey the o_analog controls.
 */
// Chosen here: the address map and the plain strobed port.
`timescale 1ns/1ps

// Function
// - Result high when positive exceeds negative.
// - Result held low while comparator disabled.
// - Each terminal's pin connection software selectable.
// - Exchange swaps terminals and inverts result.
// - Short bit ties both terminals together.
// - Filter bit selects filtered or raw result.
// - Level select drives reference generator output.
// - Reference applied to selected terminal.
// - Disable bit turns off pin buffers.
// - Selected input pins have buffers disabled.
// - One flag and one interrupt vector.
// - Flag set on selected result edge.
// - Request needs local and global enable.
// - Flag cleared by service or software.
// - Edge select change may set flag.
// - Result routed to timer capture input.
// - Edge select zero rising, one falling.
// - Level codes: off, quarter, half, diode.
module acc_ctrl import acc_pkg::*; #(
    parameter int FILT_CYC = ACC_FILT_CYC
) (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst,
    // Register port
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    // Comparator and pins
    input wire logic i_cmp_raw,
    output acc_analog_t o_analog,
    output logic [7:0] o_pin_buf_off,
    // Interrupt controller and timer
    input wire logic i_irq_ack,
    output logic o_irq_req,
    output logic o_timer_capture_input
);

    logic [7:0] ctl1_r, ctl1_nxt;
    logic [7:0] ctl2_r, ctl2_nxt;
    logic [7:0] pd_r, pd_nxt;
    logic gie_r, gie_nxt;
    logic flag_r, flag_nxt;
    logic [7:0] rdata_r, rdata_nxt;
    logic sync1_r, sync2_r, sync1_nxt, sync2_nxt;
    logic res_r, res_nxt;
    logic filt_r, filt_nxt;
    logic filt_prev_r;
    logic [7:0] fcnt_r, fcnt_nxt;
    logic comparator_result;
    logic pos_sel, res_edge, ies_change, new_ies;
    logic [1:0] sel_pos;
    logic [2:0] sel_neg;
    logic [7:0] pos_pins, neg_pins;

    wire logic input_exchange = ctl1_r[ACC_C1_EXCH];
    wire logic comparator_enable = ctl1_r[ACC_C1_ON];
    wire logic irq_edge_select = ctl1_r[ACC_C1_IES];
    wire logic cmp_irq_enable = ctl1_r[ACC_C1_IE];
    wire logic output_filter_enable = ctl2_r[ACC_C2_FILT];

    // Terminal input decode: the two-bit group feeds one terminal, the three-bit group the other.
    always_comb begin
        sel_pos = {ctl2_r[ACC_C2_SEL4], ctl2_r[ACC_C2_SEL0]};
        sel_neg = ctl2_r[ACC_C2_SEL_MID +: 3];
        pos_pins = 8'h00;
        neg_pins = 8'h00;
        if (sel_pos != 2'h0) begin
            pos_pins[sel_pos - 2'h1] = 1'b1;
        end
        if (sel_neg != 3'h0) begin
            neg_pins[sel_neg] = 1'b1;
        end
    end

    always_comb begin
        o_analog.pin_to_pos = input_exchange ? neg_pins : pos_pins;
        o_analog.pin_to_neg = input_exchange ? pos_pins : neg_pins;
        o_analog.short_en = ctl2_r[ACC_C2_SHORT];
        o_analog.cmp_on = comparator_enable;
        o_analog.ref_level = acc_ref_t'(ctl1_r[ACC_C1_REF_LO +: 2]);
        pos_sel = ctl1_r[ACC_C1_RSEL] ~^ input_exchange;
        o_analog.ref_to_pos = pos_sel && (o_analog.ref_level != ACC_REF_OFF);
        o_analog.ref_to_neg = !pos_sel && (o_analog.ref_level != ACC_REF_OFF);
        // Selected pins lose their buffers even without their disable bit.
        o_pin_buf_off = pd_r | pos_pins | neg_pins;
    end

    // Result path: synchronise, invert on exchange, gate by enable, optional filter.
    always_comb begin
        sync1_nxt = i_cmp_raw;
        sync2_nxt = sync1_r;
        res_nxt = comparator_enable && (sync2_r ^ input_exchange);
        filt_nxt = filt_r;
        fcnt_nxt = 8'h00;
        // While enabled, the filter only lets a level through after it has stood FILT_CYC cycles; disable forces it low at once.
        if (res_r != filt_r) begin
            fcnt_nxt = fcnt_r + 8'h01;
            if (fcnt_r >= 8'(FILT_CYC - 1)) begin
                filt_nxt = res_r;
                fcnt_nxt = 8'h00;
            end
        end
        if (!comparator_enable) begin
            filt_nxt = 1'b0;
        end
    end

    assign comparator_result = output_filter_enable ? filt_r : res_r;
    assign o_timer_capture_input = comparator_result;

    // Register writes and the interrupt flag.
    always_comb begin
        ctl1_nxt = ctl1_r;
        ctl2_nxt = ctl2_r;
        pd_nxt = pd_r;
        gie_nxt = gie_r;
        flag_nxt = flag_r;
        rdata_nxt = 8'h00;
        new_ies = irq_edge_select;
        if (i_wr) begin
            case (i_addr)
                ACC_CTL1_IDX: begin
                    ctl1_nxt = {i_wdata[7:1], 1'b0};
                    new_ies = i_wdata[ACC_C1_IES];
                    flag_nxt = i_wdata[ACC_C1_IFG];
                end
                ACC_CTL2_IDX: ctl2_nxt = {i_wdata[7:1], ctl2_r[ACC_C2_RES]};
                ACC_PD_IDX: pd_nxt = i_wdata;
                ACC_IRQ_IDX: gie_nxt = i_wdata[ACC_IRQ_GIE];
                default: ;
            endcase
        end
        if (i_irq_ack) begin
            flag_nxt = 1'b0;
        end
        // Edge is taken from the previous result against the current one.
        res_edge = irq_edge_select ? (filt_prev_r && !comparator_result)
                                   : (!filt_prev_r && comparator_result);
        ies_change = (new_ies != irq_edge_select) && (comparator_result != new_ies);
        // A hardware set wins over any clear in the same cycle.
        if (res_edge || ies_change) begin
            flag_nxt = 1'b1;
        end
        ctl2_nxt[ACC_C2_RES] = comparator_result;
        if (i_rd) begin
            case (i_addr)
                ACC_CTL1_IDX: rdata_nxt = {ctl1_r[7:1], flag_r};
                ACC_CTL2_IDX: rdata_nxt = {ctl2_r[7:1], comparator_result};
                ACC_PD_IDX: rdata_nxt = pd_r;
                ACC_IRQ_IDX: rdata_nxt = {7'h00, gie_r};
                default: rdata_nxt = 8'h00;
            endcase
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            ctl1_r <= ACC_CTL1_RST;
            ctl2_r <= ACC_CTL2_RST;
            pd_r <= ACC_PD_RST;
            gie_r <= 1'b0;
            flag_r <= 1'b0;
            rdata_r <= 8'h00;
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
            res_r <= 1'b0;
            filt_r <= 1'b0;
            fcnt_r <= 8'h00;
            filt_prev_r <= 1'b0;
        end else begin
            ctl1_r <= ctl1_nxt;
            ctl2_r <= ctl2_nxt;
            pd_r <= pd_nxt;
            gie_r <= gie_nxt;
            flag_r <= flag_nxt;
            rdata_r <= rdata_nxt;
            sync1_r <= sync1_nxt;
            sync2_r <= sync2_nxt;
            res_r <= res_nxt;
            filt_r <= filt_nxt;
            fcnt_r <= fcnt_nxt;
            filt_prev_r <= comparator_result;
        end
    end

    // The single request line is the one vector of this block.
    assign o_irq_req = flag_r && cmp_irq_enable && gie_r;
    assign o_rdata = rdata_r;

    result_off_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
        !comparator_enable |=> !res_r)
        else $error("result not low while comparator off");

    result_path_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
        comparator_enable |=> res_r == ($past(sync2_r) ^ $past(input_exchange)))
        else $error("result does not follow exchanged input");

    sync_delay_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
        ##2 sync2_r == $past(i_cmp_raw, 2))
        else $error("synchroniser delay is not two cycles");

    rise_sets_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (!irq_edge_select && !filt_prev_r && comparator_result) |=> flag_r)
        else $error("rising edge did not set flag");

    fall_sets_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (irq_edge_select && filt_prev_r && !comparator_result) |=> flag_r)
        else $error("falling edge did not set flag");

    irq_gate_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (i_wr && (i_addr == ACC_IRQ_IDX) && !i_wdata[ACC_IRQ_GIE]) |=> !o_irq_req)
        else $error("request while global enable off");

    ack_clear_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (i_irq_ack && !res_edge && !ies_change) |=> !flag_r)
        else $error("service did not clear flag");

    buf_off_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (ctl2_r[ACC_C2_SEL_MID +: 3] == 3'h0) || o_pin_buf_off[ctl2_r[ACC_C2_SEL_MID +: 3]])
        else $error("selected pin buffer left on");

    capture_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (comparator_enable && !output_filter_enable) |=> (output_filter_enable ||
            (o_timer_capture_input == ($past(sync2_r) ^ $past(input_exchange)))))
        else $error("timer capture input not the result");

    // The capture line is checked on its own, since the timer sees it even with reads idle.
    capture_off_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
        !comparator_enable |=> !o_timer_capture_input)
        else $error("capture input high while comparator off");

    route_neg_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (!input_exchange && (ctl2_r[ACC_C2_SEL_MID +: 3] != 3'h0))
            |-> o_analog.pin_to_neg[ctl2_r[ACC_C2_SEL_MID +: 3]])
        else $error("negative terminal pin not connected");

    route_swap_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (input_exchange && (ctl2_r[ACC_C2_SEL_MID +: 3] != 3'h0))
            |-> o_analog.pin_to_pos[ctl2_r[ACC_C2_SEL_MID +: 3]])
        else $error("exchange did not swap terminal pins");

    neg_onehot_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
        $countones(o_analog.pin_to_neg) <= 1)
        else $error("more than one pin on negative terminal");

    pos_onehot_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
        $countones(o_analog.pin_to_pos) <= 1)
        else $error("more than one pin on positive terminal");

    short_follow_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (i_wr && (i_addr == ACC_CTL2_IDX)) |=> (o_analog.short_en == $past(i_wdata[ACC_C2_SHORT])))
        else $error("short switch does not follow its bit");

    filter_hold_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (comparator_enable && (res_r == filt_r)) |=> $stable(filt_r))
        else $error("filtered result moved without a change");

    ref_level_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (i_wr && (i_addr == ACC_CTL1_IDX))
            |=> (o_analog.ref_level == acc_ref_t'($past(i_wdata[ACC_C1_REF_LO +: 2]))))
        else $error("reference level does not follow its field");

    ref_off_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (o_analog.ref_level == ACC_REF_OFF) |-> !(o_analog.ref_to_pos || o_analog.ref_to_neg))
        else $error("reference applied while off");

    ref_term_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (o_analog.ref_level != ACC_REF_OFF) |-> (o_analog.ref_to_pos != o_analog.ref_to_neg))
        else $error("reference not on exactly one terminal");

    pd_bufs_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (i_wr && (i_addr == ACC_PD_IDX)) |=> ((o_pin_buf_off & $past(i_wdata)) == $past(i_wdata)))
        else $error("disabled pin buffer left on");

    sw_clear_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (i_wr && (i_addr == ACC_CTL1_IDX) && !i_wdata[ACC_C1_IFG] && !res_edge && !ies_change)
            |=> !flag_r)
        else $error("software did not clear flag");

    ies_set_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (i_wr && (i_addr == ACC_CTL1_IDX) && i_wdata[ACC_C1_IES] && !irq_edge_select
            && !comparator_result) |=> flag_r)
        else $error("edge select change did not set flag");

    irq_local_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (i_wr && (i_addr == ACC_CTL1_IDX) && !i_wdata[ACC_C1_IE]) |=> !o_irq_req)
        else $error("request while local enable off");

    flag_quiet_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (!flag_r && !i_wr && (comparator_result == filt_prev_r)) |=> !flag_r)
        else $error("flag set without an edge");

endmodule // acc_ctrl

// >>> tb/acc_cmp_model.sv
/*
 * Behavioural stand-in for the analog comparator and the pins behind the
 * input switches. Assumes the bench gives each pin a digital proxy level.
 */
`timescale 1ns/1ps
module acc_cmp_model import acc_pkg::*; (
    // Switch controls and pin levels
    input wire acc_analog_t i_analog,
    input wire logic [7:0] i_lvl,
    // Raw comparator output
    output logic o_raw
);
    logic v_pos;
    logic v_neg;
    // A shorted pair sits at one voltage, so the output cannot go high.
    assign v_pos = |(i_analog.pin_to_pos & i_lvl);
    assign v_neg = |(i_analog.pin_to_neg & i_lvl) | (i_analog.short_en & v_pos);
    // A powered-down comparator's raw pin is not trusted, so it stays live and the block must gate.
    assign o_raw = v_pos & ~v_neg;
endmodule // acc_cmp_model

// >>> tb/analog_comparator_control_tb.sv
/*
 * Self-checking bench for the comparator control block.
 * Assumes the analog side behaves as the comparator model describes.
 */
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin n_errors++; \
    $display("unexpected t=%0t got %h exp %h", $time, a, b); end end
module analog_comparator_control_tb import acc_pkg::*;;
    logic i_core_clk = 0;
    logic i_rst = 1;
    logic [7:0] i_addr = 0;
    logic [7:0] i_wdata = 0;
    logic i_wr = 0;
    logic i_rd = 0;
    logic i_irq_ack = 0;
    logic [7:0] lvl = 0;
    logic [7:0] o_rdata;
    logic raw;
    logic o_irq_req;
    logic o_cap;
    logic [7:0] o_pin_buf_off;
    acc_analog_t o_analog;
    logic [7:0] d;
    int n_errors = 0;
    int n_checks = 0;
    acc_ctrl #(.FILT_CYC(2)) uut (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_cmp_raw(raw),
        .o_analog(o_analog), .o_pin_buf_off(o_pin_buf_off), .i_irq_ack(i_irq_ack),
        .o_irq_req(o_irq_req), .o_timer_capture_input(o_cap));
    acc_cmp_model model (.i_analog(o_analog), .i_lvl(lvl), .o_raw(raw));
    initial begin
        forever #2.5 i_core_clk = ~i_core_clk;
    end
    task automatic conclude();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge i_core_clk);
        i_wr <= 1; i_addr <= a; i_wdata <= v;
        @(posedge i_core_clk);
        i_wr <= 0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge i_core_clk);
        i_rd <= 1; i_addr <= a;
        @(posedge i_core_clk);
        i_rd <= 0;
        #1 d = o_rdata;
    endtask
    task automatic wait_cap(input logic v);
        int i;
        for (i = 0; i < 40 && o_cap !== v; i++) begin
            @(posedge i_core_clk);
            #1;
        end
        if (o_cap !== v) begin
            n_errors++;
            conclude();
        end
        repeat (3) @(posedge i_core_clk);
        #1;
    endtask
    task automatic t_regs();
        rd(ACC_CTL1_IDX); `CHK(d, ACC_CTL1_RST)
        rd(ACC_PD_IDX); `CHK(d, ACC_PD_RST)
        `CHK(o_analog, acc_analog_t'(0))
        wr(ACC_CTL1_IDX, 8'h72); rd(ACC_CTL1_IDX); `CHK(d, 8'h72)
        wr(ACC_PD_IDX, 8'ha5); rd(ACC_PD_IDX); `CHK(d, 8'ha5)
        wr(ACC_CTL2_IDX, 8'h7f); rd(ACC_CTL2_IDX); `CHK(d, 8'h7e)
        rd(8'h07); `CHK(d, 8'h00)
        wr(ACC_CTL1_IDX, 8'h00); wr(ACC_CTL2_IDX, 8'h00); wr(ACC_PD_IDX, 8'h00);
        $display("test regs done");
    endtask
    task automatic t_enable();
        wr(ACC_CTL2_IDX, 8'h04); lvl <= 8'h01;
        repeat (20) @(posedge i_core_clk);
        #1 `CHK(o_cap, 1'b0)
        wr(ACC_CTL1_IDX, 8'h08); wait_cap(1'b1);
        rd(ACC_CTL2_IDX); `CHK(d[ACC_C2_RES], 1'b1)
        wr(ACC_CTL2_IDX, 8'h06); lvl <= 8'h00;
        repeat (3) @(posedge i_core_clk);
        #1 `CHK(o_cap, 1'b1)
        wait_cap(1'b0);
        lvl <= 8'h01; wait_cap(1'b1);
        $display("test enable done");
    endtask
    task automatic t_route();
        logic [7:0] ep;
        logic [7:0] en;
        wr(ACC_PD_IDX, 8'h80); wr(ACC_CTL2_IDX, 8'h0c);
        `CHK(o_analog.pin_to_pos, 8'h01)
        `CHK(o_analog.pin_to_neg, 8'h02)
        `CHK(o_pin_buf_off, 8'h83)
        wr(ACC_CTL1_IDX, 8'h88);
        `CHK(o_analog.pin_to_pos, 8'h02)
        wait_cap(1'b1);
        `CHK(o_cap, 1'b1)
        wr(ACC_CTL2_IDX, 8'h8c); `CHK(o_analog.short_en, 1'b1)
        for (int c = 0; c < 16; c++) begin
            wr(ACC_CTL1_IDX, {c[3], c[2], c[1:0], 4'h8});
            `CHK(o_analog.ref_level, acc_ref_t'(c[1:0]))
            if (c[1:0] != 0) `CHK(o_analog.ref_to_pos, c[3] == c[2])
        end
        wr(ACC_CTL1_IDX, 8'h00); wr(ACC_CTL2_IDX, 8'h04); wr(ACC_PD_IDX, 8'h00);
        for (int p = 0; p < 4; p++) begin
            for (int n = 0; n < 8; n++) begin
                wr(ACC_CTL2_IDX, {1'b0, p[1], n[2:0], p[0], 2'h0});
                ep = (p == 0) ? 8'h00 : 8'h01 << (p - 1);
                en = (n == 0) ? 8'h00 : 8'h01 << n;
                `CHK(o_analog.pin_to_pos, ep)
                `CHK(o_analog.pin_to_neg, en)
                `CHK(o_pin_buf_off, ep | en)
            end
        end
        wr(ACC_CTL2_IDX, 8'h04);
        $display("test route done");
    endtask
    task automatic t_irq();
        lvl <= 8'h00; wr(ACC_IRQ_IDX, 8'h01); wr(ACC_CTL1_IDX, 8'h0a);
        wait_cap(1'b0); wr(ACC_CTL1_IDX, 8'h0a);
        `CHK(o_irq_req, 1'b0)
        lvl <= 8'h01; wait_cap(1'b1); `CHK(o_irq_req, 1'b1)
        @(posedge i_core_clk) i_irq_ack <= 1;
        @(posedge i_core_clk) i_irq_ack <= 0;
        #1 `CHK(o_irq_req, 1'b0)
        wr(ACC_CTL1_IDX, 8'h0e); wr(ACC_CTL1_IDX, 8'h0e);
        lvl <= 8'h00; wait_cap(1'b0); `CHK(o_irq_req, 1'b1)
        wr(ACC_IRQ_IDX, 8'h00); `CHK(o_irq_req, 1'b0)
        rd(ACC_CTL1_IDX); `CHK(d[ACC_C1_IFG], 1'b1)
        wr(ACC_CTL1_IDX, 8'h0e); rd(ACC_CTL1_IDX); `CHK(d[ACC_C1_IFG], 1'b0)
        wr(ACC_IRQ_IDX, 8'h01); wr(ACC_CTL1_IDX, 8'h0d); `CHK(o_irq_req, 1'b0)
        wr(ACC_CTL1_IDX, 8'h0f); `CHK(o_irq_req, 1'b1)
        wr(ACC_CTL1_IDX, 8'h0a); wr(ACC_CTL1_IDX, 8'h0e); rd(ACC_CTL1_IDX);
        `CHK(d[ACC_C1_IFG], 1'b1)
        $display("test irq done");
    endtask
    initial begin
        repeat (4) @(posedge i_core_clk);
        i_rst <= 0;
        t_regs();
        t_enable();
        t_route();
        t_irq();
        conclude();
    end
endmodule // analog_comparator_control_tb
